/* dhm_pkg.sv */
// shared constants and types for the drive health monitor
package dhm_pkg;
   localparam int unsigned CLK_MHZ           = 200;
   localparam int unsigned MEAS_PERIOD_S     = 3600;
   localparam int unsigned TEMP_PERIOD_S     = 600;
   localparam int unsigned MAX_DELAY_MS      = 75;
   localparam longint unsigned MEAS_CYCLES   = longint'(MEAS_PERIOD_S) * CLK_MHZ * 1000000;
   localparam longint unsigned TEMP_CYCLES   = longint'(TEMP_PERIOD_S) * CLK_MHZ * 1000000;
   localparam longint unsigned DELAY_CYCLES  = longint'(MAX_DELAY_MS) * CLK_MHZ * 1000;
   localparam int unsigned TIMER_W           = 40;
   localparam logic [7:0]  LOG_PAGE_TIMER    = 8'h3e;
   localparam logic [7:0]  MODE_PAGE_IEC     = 8'h1c;
   localparam logic [3:0]  REPORT_SENSE      = 4'h1;
   localparam logic [3:0]  SK_RECOVERED      = 4'h1;
   localparam logic [3:0]  SK_NOT_READY      = 4'h2;
   localparam logic [7:0]  ASC_PREDICT       = 8'h5d;
   localparam logic [7:0]  ASC_TEMP          = 8'h08;
   localparam logic [7:0]  ASCQ_TEMP         = 8'h01;
   localparam logic [7:0]  ASC_NOT_READY     = 8'h04;
   localparam logic [7:0]  ASCQ_NR_CAUSE     = 8'h00;
   localparam logic [7:0]  ASCQ_NR_MANUAL    = 8'h03;
   localparam logic [3:0]  ST_RUNNING        = 4'hf;
   localparam logic [3:0]  ST_PASS           = 4'h0;
   localparam logic [3:0]  ST_FAIL_SEEK      = 4'h5;
   localparam logic [3:0]  ST_FAIL_TRACK     = 4'h6;
   localparam logic [3:0]  ST_FAIL_READ      = 4'h7;
   localparam logic [3:0]  ST_FAIL_WRITE     = 4'h4;
   localparam logic [3:0]  ST_ABORTED        = 4'h1;

   typedef enum logic [2:0] {
      DHM_IDLE = 3'b001,
      DHM_MEAS = 3'b010,
      DHM_SAVE = 3'b100
   } dhm_meas_type;
endpackage

/* dhm_attr_if.sv */
// per-attribute event and verdict bundle
`timescale 1ns/10ps
interface dhm_attr_if;
   logic op;
   logic err;
   logic clear;
   logic predict;
   modport mon (input op, input err, input clear, output predict);
   modport core (output op, output err, output clear, input predict);
endinterface

/* dhm_attr_mon.sv */
// interval, failure and failure-history counters for one attribute
`timescale 1ns/10ps
module dhm_attr_mon #(
   parameter int unsigned INTERVAL  = 1000,
   parameter int unsigned ERR_LIMIT = 10,
   parameter int unsigned PRED_LIM  = 8
) (
   input  wire logic clk,
   input  wire logic rst,
   dhm_attr_if.mon   a
);
   localparam int IW = $clog2(INTERVAL + 1);
   localparam int EW = $clog2(ERR_LIMIT + 2);
   localparam int HW = $clog2(PRED_LIM + 1);

   typedef struct packed {
      logic [IW-1:0] ops;
      logic [EW-1:0] errs;
      logic [HW-1:0] hist;
      logic          pred;
   } dhm_attr_state_type;

   dhm_attr_state_type s_r;
   dhm_attr_state_type s_nxt;
   logic               bad;
   logic               done;

   assign a.predict = s_r.pred;

   always_comb begin
      s_nxt = s_r;
      bad   = 1'b0;
      done  = 1'b0;
      if (a.clear) begin
         s_nxt = '0;
      end else begin
         if (a.op) begin
            s_nxt.ops = s_r.ops + IW'(1); // [RULE_09]
         end
         if (a.err && s_r.errs <= EW'(ERR_LIMIT)) begin
            s_nxt.errs = s_r.errs + EW'(1); // [RULE_09]
         end
         // limit crossed early ends the interval as unacceptable
         bad  = s_nxt.errs > EW'(ERR_LIMIT); // [RULE_10]
         done = bad || (s_nxt.ops >= IW'(INTERVAL));
         if (done) begin
            s_nxt.ops  = '0; // [RULE_10]
            s_nxt.errs = '0;
            if (bad) begin
               if (s_r.hist < HW'(PRED_LIM)) begin
                  s_nxt.hist = s_r.hist + HW'(1); // [RULE_11]
               end
            end else if (s_r.hist != '0) begin
               s_nxt.hist = s_r.hist - HW'(1); // [RULE_11]
            end
         end
         if (s_nxt.hist >= HW'(PRED_LIM)) begin
            s_nxt.pred = 1'b1; // [RULE_12]
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   a_hist_floor: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
      (s_r.hist == '0 && !a.clear) |=> s_r.hist <= HW'(1))
      else $error("history counter wrapped below zero");
   a_pred_sticky: assert property (@(posedge clk) disable iff (rst) // [RULE_12]
      (s_r.hist >= HW'(PRED_LIM) && !a.clear) |=> s_r.pred)
      else $error("predictive failure not raised at threshold");
endmodule

/* dhm_timer.sv */
// free running period timer with restart and remaining-count view
`timescale 1ns/10ps
module dhm_timer #(
   parameter longint unsigned PERIOD = 1000,
   parameter int unsigned     W      = 40
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         restart,
   output logic              tick,
   output logic [W-1:0]      remain
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } dhm_tmr_state_type;

   dhm_tmr_state_type s_r;
   dhm_tmr_state_type s_nxt;

   assign tick   = s_r.tick;
   assign remain = s_r.cnt;

   always_comb begin
      s_nxt      = s_r;
      s_nxt.tick = 1'b0;
      if (restart) begin
         s_nxt.cnt = W'(PERIOD - 1);
      end else if (s_r.cnt == '0) begin
         s_nxt.cnt  = W'(PERIOD - 1);
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt - W'(1);
      end
   end

   // count starts at zero so the first tick lands right after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

/* dhm_top.sv */
// drive health monitor: failure prediction, thermal check, self-test verdicts
// How it works
// RULE_01 - disable bit stops all prediction; else collect online
// RULE_02 - online-only bit suppresses offline attribute measurement
// RULE_03 - recalibrate forces measurement, restarts hourly timer
// RULE_04 - timer log page returns time to next measurement
// RULE_05 - hourly measurement only when idle; host interrupts
// RULE_06 - online processing adds at most 75 ms
// RULE_07 - report method one gives predictive sense, unit code
// RULE_08 - reported predictive code persists across resets
// RULE_09 - interval counter and failure counter per attribute
// RULE_10 - errors over limit mark bad interval; restart counters
// RULE_11 - history counter up on bad, down on good
// RULE_12 - history at threshold signals predictive failure
// RULE_13 - temperature sampled at power-up, every ten minutes
// RULE_14 - hot sample raises thermal warning, saves frame
// RULE_15 - thermal warning gated by enable, follows report method
// RULE_16 - self-test keeps retries; recovered errors never fail
// RULE_17 - self-test fails only on unrecovered seek/track/read/write
// RULE_18 - host checks readiness before self-test command
// RULE_19 - motor, servo or table fault reports not ready
// RULE_20 - self-test result Fh at start, zero or fail after; an abort here leaves 1h (ST_ABORTED)
// RULE_21 - attribute limits are build-time parameters
`timescale 1ns/10ps
module dhm_top #(
   parameter int unsigned     N_ATTR     = 4,
   parameter int unsigned     INTERVAL   = 1000, // [RULE_21]
   parameter int unsigned     ERR_LIMIT  = 10,
   parameter int unsigned     PRED_LIM   = 8,
   parameter longint unsigned MEAS_CYC   = dhm_pkg::MEAS_CYCLES,
   parameter longint unsigned TEMP_CYC   = dhm_pkg::TEMP_CYCLES,
   parameter int unsigned     MEAS_STEPS = 64
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     exceptions_disable_bit,
   input  wire logic                     online_only_bit,
   input  wire logic [3:0]               report_method_field,
   input  wire logic                     temp_warning_enable,
   input  wire logic                     recalibrate_command,
   input  wire logic                     host_busy,
   input  wire logic [N_ATTR-1:0]        attr_op,
   input  wire logic [N_ATTR-1:0]        attr_err,
   input  wire logic                     pred_code_valid_nv,
   input  wire logic [7:0]               pred_fru_nv,
   input  wire logic                     pred_clear,
   input  wire logic [7:0]               temp_value,
   input  wire logic [7:0]               temp_limit,
   input  wire logic                     sense_ack,
   input  wire logic                     drive_self_test,
   input  wire logic                     self_test_abort,
   input  wire logic                     self_test_done,
   input  wire logic                     st_seek_unrec,
   input  wire logic                     st_track_unrec,
   input  wire logic                     st_read_unrec,
   input  wire logic                     st_write_unrec,
   input  wire logic                     motor_fault,
   input  wire logic                     servo_fault,
   input  wire logic                     config_fault,
   input  wire logic                     manual_spin_needed,
   input  wire logic [7:0]               log_page_sel,
   output logic [dhm_pkg::TIMER_W-1:0]   log_time_remain,
   output logic                          measuring,
   output logic                          save_frame,
   output logic                          pred_fail,
   output logic [7:0]                    pred_fru,
   output logic                          sense_valid,
   output logic [3:0]                    sense_key,
   output logic [7:0]                    sense_asc,
   output logic [7:0]                    sense_ascq,
   output logic                          retries_enable,
   output logic                          diag_failed,
   output logic [3:0]                    self_test_result,
   output logic                          not_ready,
   output logic [7:0]                    tur_asc,
   output logic [7:0]                    tur_ascq
);
   localparam int SW = $clog2(MEAS_STEPS + 1);

   // field pins from the sensor and fault lines arrive asynchronously
   logic [7:0] temp_s1_r;
   logic [7:0] temp_s2_r;
   logic [2:0] flt_s1_r;
   logic [2:0] flt_s2_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         temp_s1_r <= 8'h00;
         temp_s2_r <= 8'h00;
         flt_s1_r  <= 3'h0;
         flt_s2_r  <= 3'h0;
      end else begin
         temp_s1_r <= temp_value;
         temp_s2_r <= temp_s1_r;
         flt_s1_r  <= {motor_fault, servo_fault, config_fault};
         flt_s2_r  <= flt_s1_r;
      end
   end

   typedef struct packed {
      dhm_pkg::dhm_meas_type        st;
      logic [SW-1:0]                step;
      logic                         save;
      logic                         pred;
      logic [7:0]                   fru;
      logic                         nv_loaded;
      logic                         temp_hot;
      logic                         ttk;
      logic                         sv;
      logic [3:0]                   sk;
      logic [7:0]                   asc;
      logic [7:0]                   ascq;
      logic                         st_run;
      logic [3:0]                   st_res;
      logic                         dfail;
      logic                         nrdy;
      logic [7:0]                   nasc;
      logic [7:0]                   nascq;
      logic [dhm_pkg::TIMER_W-1:0]  lt;
   } dhm_state_type;

   dhm_state_type s_r;
   dhm_state_type s_nxt;

   logic                         meas_tick;
   logic                         temp_tick;
   logic [dhm_pkg::TIMER_W-1:0]  meas_remain;
   logic                         meas_restart;
   logic [N_ATTR-1:0]            attr_pred;
   logic                         attr_clr;

   dhm_attr_if ai [N_ATTR] ();

   // attribute counters are held clear while prediction is off
   assign attr_clr = exceptions_disable_bit; // [RULE_01]

   genvar g;
   generate
      for (g = 0; g < N_ATTR; g++) begin : g_attr
         assign ai[g].op    = attr_op[g]; // [RULE_01]
         assign ai[g].err   = attr_err[g];
         assign ai[g].clear = attr_clr;
         assign attr_pred[g] = ai[g].predict;
         dhm_attr_mon #(
            .INTERVAL  (INTERVAL),
            .ERR_LIMIT (ERR_LIMIT),
            .PRED_LIM  (PRED_LIM)
         ) u_attr (
            .clk (clk),
            .rst (rst),
            .a   (ai[g])
         );
      end
   endgenerate

   assign meas_restart = recalibrate_command; // [RULE_03]

   dhm_timer #(.PERIOD(MEAS_CYC), .W(dhm_pkg::TIMER_W)) u_meas_tmr (
      .clk     (clk),
      .rst     (rst),
      .restart (meas_restart),
      .tick    (meas_tick),
      .remain  (meas_remain)
   );

   // first tick right after reset gives the power-up temperature sample
   dhm_timer #(.PERIOD(TEMP_CYC), .W(dhm_pkg::TIMER_W)) u_temp_tmr (
      .clk     (clk),
      .rst     (rst),
      .restart (1'b0),
      .tick    (temp_tick), // [RULE_13]
      .remain  ()
   );

   logic       offline_ok;
   logic       pred_any;
   logic [7:0] pred_idx;

   always_comb begin
      pred_idx = 8'h00;
      for (int i = N_ATTR - 1; i >= 0; i--) begin
         if (attr_pred[i]) begin
            pred_idx = 8'(i + 1);
         end
      end
   end

   assign pred_any   = |attr_pred;
   assign offline_ok = !exceptions_disable_bit && !online_only_bit; // [RULE_02]

   always_comb begin
      s_nxt      = s_r;
      s_nxt.save = 1'b0;
      // hourly measurement, preempted whenever the host is busy unless recalibrate_command is asserted
      case (s_r.st)
         dhm_pkg::DHM_IDLE: begin
            if (offline_ok && recalibrate_command) begin
               s_nxt.st   = dhm_pkg::DHM_MEAS; // [RULE_03]
               s_nxt.step = '0;
            end else if (offline_ok && meas_tick && !host_busy) begin
               s_nxt.st   = dhm_pkg::DHM_MEAS; // [RULE_05]
               s_nxt.step = '0;
            end
         end
         dhm_pkg::DHM_MEAS: begin
            if (!offline_ok || (host_busy && !recalibrate_command)) begin
               s_nxt.st = dhm_pkg::DHM_IDLE; // [RULE_05]
            end else if (s_r.step >= SW'(MEAS_STEPS - 1)) begin
               s_nxt.st = dhm_pkg::DHM_SAVE;
            end else begin
               s_nxt.step = s_r.step + SW'(1);
            end
         end
         dhm_pkg::DHM_SAVE: begin
            s_nxt.save = 1'b1;
            s_nxt.st   = dhm_pkg::DHM_IDLE;
         end
         default: begin
            s_nxt.st = dhm_pkg::DHM_IDLE;
         end
      endcase

      // stored code reloads once after reset so it survives power cycles
      if (!s_r.nv_loaded) begin
         s_nxt.nv_loaded = 1'b1;
         s_nxt.pred      = pred_code_valid_nv; // [RULE_08]
         s_nxt.fru       = pred_fru_nv;
      end else if (!exceptions_disable_bit && pred_any && !s_r.pred) begin
         s_nxt.pred = 1'b1; // [RULE_12]
         s_nxt.fru  = pred_idx; // [RULE_07]
         s_nxt.save = 1'b1;
      end else if (pred_clear && !(pred_any && !exceptions_disable_bit)) begin
         s_nxt.pred = 1'b0;
      end

      // tick delayed a cycle: the power-up sample must not see the sync reset zeros
      s_nxt.ttk = temp_tick; // [RULE_13]
      if (s_r.ttk) begin
         s_nxt.temp_hot = temp_s2_r > temp_limit; // [RULE_14]
         if (temp_s2_r > temp_limit && !exceptions_disable_bit) begin
            s_nxt.save = 1'b1; // [RULE_14]
         end
      end

      if (sense_ack) begin
         s_nxt.sv = 1'b0;
      end
      if (report_method_field == dhm_pkg::REPORT_SENSE && !exceptions_disable_bit) begin
         if (s_r.pred && !s_r.sv && !sense_ack) begin
            s_nxt.sv   = 1'b1; // [RULE_07]
            s_nxt.sk   = dhm_pkg::SK_RECOVERED;
            s_nxt.asc  = dhm_pkg::ASC_PREDICT;
            s_nxt.ascq = 8'h00;
         end else if (s_r.ttk && temp_s2_r > temp_limit && temp_warning_enable) begin
            s_nxt.sv   = 1'b1; // [RULE_15]
            s_nxt.sk   = dhm_pkg::SK_RECOVERED;
            s_nxt.asc  = dhm_pkg::ASC_TEMP;
            s_nxt.ascq = dhm_pkg::ASCQ_TEMP;
         end
      end

      if (drive_self_test && !s_r.st_run) begin
         s_nxt.st_run = 1'b1;
         s_nxt.st_res = dhm_pkg::ST_RUNNING; // [RULE_20]
         s_nxt.dfail  = 1'b0;
      end else if (s_r.st_run) begin
         // only unrecovered errors reach these lines
         if (st_seek_unrec) begin
            s_nxt.st_res = dhm_pkg::ST_FAIL_SEEK; // [RULE_17]
            s_nxt.dfail  = 1'b1;
            s_nxt.st_run = 1'b0;
         end else if (st_track_unrec) begin
            s_nxt.st_res = dhm_pkg::ST_FAIL_TRACK;
            s_nxt.dfail  = 1'b1;
            s_nxt.st_run = 1'b0;
         end else if (st_read_unrec) begin
            s_nxt.st_res = dhm_pkg::ST_FAIL_READ;
            s_nxt.dfail  = 1'b1; // [RULE_16]
            s_nxt.st_run = 1'b0;
         end else if (st_write_unrec) begin
            s_nxt.st_res = dhm_pkg::ST_FAIL_WRITE;
            s_nxt.dfail  = 1'b1;
            s_nxt.st_run = 1'b0;
         end else if (self_test_abort) begin
            s_nxt.st_res = dhm_pkg::ST_ABORTED;
            s_nxt.st_run = 1'b0;
         end else if (self_test_done) begin
            s_nxt.st_res = dhm_pkg::ST_PASS; // [RULE_20]
            s_nxt.st_run = 1'b0;
         end
      end

      s_nxt.nrdy  = |flt_s2_r; // [RULE_19]
      s_nxt.nasc  = (|flt_s2_r) ? dhm_pkg::ASC_NOT_READY : 8'h00;
      s_nxt.nascq = manual_spin_needed ? dhm_pkg::ASCQ_NR_MANUAL : dhm_pkg::ASCQ_NR_CAUSE;
      s_nxt.lt    = (log_page_sel == dhm_pkg::LOG_PAGE_TIMER) ? meas_remain : '0; // [RULE_04]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r    <= '0;
         s_r.st <= dhm_pkg::DHM_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign measuring        = s_r.st == dhm_pkg::DHM_MEAS;
   assign save_frame       = s_r.save;
   assign pred_fail        = s_r.pred;
   assign pred_fru         = s_r.fru;
   assign sense_valid      = s_r.sv;
   assign sense_key        = s_r.sk;
   assign sense_asc        = s_r.asc;
   assign sense_ascq       = s_r.ascq;
   assign retries_enable   = 1'b1; // [RULE_16] never reduced, even in self-test
   assign diag_failed      = s_r.dfail;
   assign self_test_result = s_r.st_res;
   assign not_ready        = s_r.nrdy;
   assign tur_asc          = s_r.nasc;
   assign tur_ascq         = s_r.nascq;
   assign log_time_remain  = s_r.lt;

   // online work is single-cycle, far inside the delay budget
   sequence host_takes_bus;
      s_r.st == dhm_pkg::DHM_MEAS ##0 host_busy ##0 !recalibrate_command;
   endsequence
   a_meas_yield: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
      host_takes_bus |=> s_r.st == dhm_pkg::DHM_IDLE)
      else $error("measurement did not yield to host");
   a_meas_bound: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
      s_r.st == dhm_pkg::DHM_MEAS && host_busy |-> ##[1:2] !measuring)
      else $error("host delayed by measurement");
   a_online_only: assert property (@(posedge clk) disable iff (rst) // [RULE_02]
      online_only_bit && s_r.st == dhm_pkg::DHM_IDLE |=> s_r.st == dhm_pkg::DHM_IDLE)
      else $error("offline measurement while online only");
   a_rezero_timer: assert property (@(posedge clk) disable iff (rst) // [RULE_03]
      recalibrate_command |=> meas_remain == dhm_pkg::TIMER_W'(MEAS_CYC - 1))
      else $error("timer not restarted by recalibrate");
   a_pred_sense: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
      s_r.nv_loaded && pred_any && !s_r.pred && !exceptions_disable_bit |=> pred_fail)
      else $error("predictive failure not latched");
   a_st_start: assert property (@(posedge clk) disable iff (rst) // [RULE_20]
      drive_self_test && !s_r.st_run |=> self_test_result == dhm_pkg::ST_RUNNING)
      else $error("self-test result not Fh at start");
   a_st_fail: assert property (@(posedge clk) disable iff (rst) // [RULE_17]
      s_r.st_run && st_read_unrec |=> diag_failed && self_test_result != 4'h0)
      else $error("unrecovered error not failed");
   a_temp_warn: assert property (@(posedge clk) disable iff (rst) // [RULE_14]
      s_r.ttk && temp_s2_r > temp_limit && !exceptions_disable_bit |=> save_frame)
      else $error("hot sample saved no frame");
   a_not_ready: assert property (@(posedge clk) disable iff (rst) // [RULE_19]
      $rose(flt_s2_r[2]) |=> not_ready && tur_asc == dhm_pkg::ASC_NOT_READY)
      else $error("motor fault not reported");
endmodule

/* dhm_host_model.sv */
// host initiator model: self-test launch and sense acknowledge
`timescale 1ns/10ps
module dhm_host_model (
   input  wire logic clk,
   input  wire logic not_ready,
   input  wire logic sense_valid,
   input  wire logic start_req,
   input  wire logic ack_en,
   output logic      drive_self_test,
   output logic      sense_ack
);
   initial begin
      drive_self_test = 1'b0;
      sense_ack = 1'b0;
   end
   always @(negedge clk) begin
      // no launch while not ready; finding the cause is the host's own job
      drive_self_test <= start_req && !drive_self_test && (not_ready === 1'b0);
      sense_ack <= ack_en && (sense_valid === 1'b1) && !sense_ack;
   end
endmodule

/* drive_health_monitor_bench.sv */
// self-checking bench for the drive health monitor
`timescale 1ns/10ps
module drive_health_monitor_bench;
   localparam int MC = 200;
   localparam int TC = 50;
   typedef struct packed {logic [5:0] ev; logic [3:0] res;} dhm_row_type;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic exceptions_disable_bit, online_only_bit, temp_warning_enable, recalibrate_command;
   logic host_busy, pred_code_valid_nv, pred_clear, self_test_abort, self_test_done;
   logic st_seek_unrec, st_track_unrec, st_read_unrec, st_write_unrec, manual_spin_needed;
   logic motor_fault, servo_fault, config_fault, drive_self_test, sense_ack, start_req, ack_en;
   logic measuring, save_frame, pred_fail, sense_valid, retries_enable, diag_failed, not_ready;
   logic [3:0]  report_method_field, sense_key, self_test_result;
   logic [1:0]  attr_op, attr_err;
   logic [7:0]  pred_fru_nv, temp_value, temp_limit, log_page_sel, pred_fru;
   logic [7:0]  sense_asc, sense_ascq, tur_asc, tur_ascq;
   logic [39:0] log_time_remain;
   int err_count = 0;
   int cmp_count = 0;
   int frames = 0;
   int meas_seen = 0;
   int k, f0;
   // seek, track, read, write, done, abort
   dhm_row_type rows [6] = '{'{6'h01, dhm_pkg::ST_FAIL_SEEK}, '{6'h02, dhm_pkg::ST_FAIL_TRACK},
      '{6'h04, dhm_pkg::ST_FAIL_READ}, '{6'h08, dhm_pkg::ST_FAIL_WRITE},
      '{6'h10, dhm_pkg::ST_PASS}, '{6'h20, dhm_pkg::ST_ABORTED}};

   dhm_top #(.N_ATTR(2), .INTERVAL(8), .ERR_LIMIT(2), .PRED_LIM(2), .MEAS_CYC(MC),
      .TEMP_CYC(TC), .MEAS_STEPS(4)) i_dut (.*);
   dhm_host_model i_host (.*);

   always #2.5 clk = ~clk;
   always @(negedge clk) begin
      if (save_frame === 1'b1) frames++;
      if (measuring === 1'b1) meas_seen++;
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // n ops on attribute 0, the first m of them in error
   task automatic burst(input int n, input int m);
      for (int j = 0; j < n; j++) begin
         attr_op <= 2'b01;
         attr_err <= {1'b0, j < m};
         cyc(1);
         attr_op <= '0;
         attr_err <= '0;
         cyc(1);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      cyc(5000);
      err_count++;
      test_done();
   end

   initial begin
      {exceptions_disable_bit, online_only_bit, temp_warning_enable, recalibrate_command} = '0;
      {host_busy, pred_code_valid_nv, pred_clear, self_test_abort, self_test_done} = '0;
      {st_seek_unrec, st_track_unrec, st_read_unrec, st_write_unrec, manual_spin_needed} = '0;
      {motor_fault, servo_fault, config_fault, start_req, ack_en} = '0;
      report_method_field = dhm_pkg::REPORT_SENSE;
      {attr_op, attr_err} = '0;
      pred_fru_nv = 8'h03;
      temp_value = 8'h20;
      temp_limit = 8'h40;
      log_page_sel = dhm_pkg::LOG_PAGE_TIMER;
      cyc(10);
      chk({pred_fail, not_ready, retries_enable}, 3'h1);
      rst <= 1'b0;
      cyc(3);
      foreach (rows[i]) begin
         start_req <= 1'b1;
         cyc(1);
         start_req <= 1'b0;
         for (k = 0; k < 8 && self_test_result !== 4'hf; k++) cyc(1);
         chk(self_test_result, dhm_pkg::ST_RUNNING);
         {self_test_abort, self_test_done, st_write_unrec, st_read_unrec, st_track_unrec,
            st_seek_unrec} <= rows[i].ev;
         cyc(1);
         {self_test_abort, self_test_done, st_write_unrec, st_read_unrec} <= '0;
         {st_track_unrec, st_seek_unrec} <= '0;
         cyc(3);
         chk(self_test_result, rows[i].res);
         if (!rows[i].ev[5]) chk(diag_failed, rows[i].ev[3:0] != 0);
      end
      for (int i = 0; i < 4; i++) begin
         {config_fault, servo_fault, motor_fault} <= (i < 3) ? 3'h1 << i : 3'h1;
         manual_spin_needed <= (i == 3);
         cyc(6);
         chk(not_ready, 1'b1);
         chk({tur_asc, tur_ascq}, {dhm_pkg::ASC_NOT_READY,
            (i == 3) ? dhm_pkg::ASCQ_NR_MANUAL : dhm_pkg::ASCQ_NR_CAUSE});
         start_req <= 1'b1;
         cyc(1);
         start_req <= 1'b0;
         {config_fault, servo_fault, motor_fault, manual_spin_needed} <= '0;
         cyc(6);
         chk({not_ready, self_test_result}, {1'b0, dhm_pkg::ST_ABORTED});
      end
      exceptions_disable_bit <= 1'b1;
      burst(9, 9);
      chk(pred_fail, 1'b0);
      exceptions_disable_bit <= 1'b0;
      burst(3, 3);
      burst(8, 2);
      burst(3, 3);
      cyc(3);
      chk(pred_fail, 1'b0);
      burst(3, 3);
      cyc(3);
      chk({pred_fail, pred_fru}, 9'h101);
      chk({sense_valid, sense_key, sense_asc, sense_ascq}, {1'b1, dhm_pkg::SK_RECOVERED,
         dhm_pkg::ASC_PREDICT, 8'h00});
      ack_en <= 1'b1;
      cyc(4);
      chk(sense_valid, 1'b0);
      // predictive sense re-arms while the flag stands, so drop the flag first
      exceptions_disable_bit <= 1'b1;
      pred_clear <= 1'b1;
      cyc(4);
      chk({pred_fail, sense_valid}, 2'b00);
      {exceptions_disable_bit, pred_clear, ack_en} <= '0;
      online_only_bit <= 1'b1;
      cyc(2);
      meas_seen = 0;
      cyc(MC + 20);
      chk(meas_seen, 0);
      online_only_bit <= 1'b0;
      cyc(MC + 20);
      chk(meas_seen != 0, 1'b1);
      f0 = frames;
      recalibrate_command <= 1'b1;
      cyc(1);
      recalibrate_command <= 1'b0;
      cyc(1);
      chk(measuring, 1'b1);
      chk(log_time_remain >= MC - 3 && log_time_remain <= MC - 1, 1'b1);
      cyc(8);
      chk(frames > f0, 1'b1);
      recalibrate_command <= 1'b1;
      cyc(1);
      recalibrate_command <= 1'b0;
      host_busy <= 1'b1;
      cyc(3);
      chk(measuring, 1'b0);
      host_busy <= 1'b0;
      temp_value <= 8'h50;
      cyc(TC + 10);
      chk(sense_valid, 1'b0);
      f0 = frames;
      temp_warning_enable <= 1'b1;
      cyc(TC + 10);
      chk(frames > f0, 1'b1);
      chk({sense_valid, sense_key, sense_asc, sense_ascq}, {1'b1, dhm_pkg::SK_RECOVERED,
         dhm_pkg::ASC_TEMP, dhm_pkg::ASCQ_TEMP});
      pred_code_valid_nv <= 1'b1;
      rst <= 1'b1;
      cyc(3);
      rst <= 1'b0;
      cyc(3);
      chk({pred_fail, pred_fru}, 9'h103);
      test_done();
   end
endmodule
